/* File: timer_map.svh */
// What this block does
// - Control bits 3..1 pick counter mode
// - Control bit 0 picks binary or BCD
// - Top bits both one mean read-back
// - Read-back bits 3,2,1 pick counters 2,1,0
// - Read-back bit5 low latches count, bit4 status
// - Latched count held until fully read
// - Latched status frozen until read
// - Status read first, then count, then live
// - Bits 5..4 zero mean single count latch
// - Latch captures present count; repeats ignored
// - Per-counter two-byte read progress kept
// - Status returned on counter's own port
// - Status bit 7 is output level
// - Status bit 6 is null count flag
// - Unloaded new count never read back
// - Status bits 5..4 echo byte access
// - Bits 5..4 select LSB, MSB, both
// - Status bits 3..0 echo mode, type
// - Reset drives counter outputs low
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

`define PORT_CNT0     8'h40
`define PORT_CNT1     8'h41
`define PORT_CNT2     8'h42
`define PORT_CTRL     8'h43

`define CW_SEL_HI     7
`define CW_SEL_LO     6
`define CW_RW_HI      5
`define CW_RW_LO      4
`define CW_MODE_HI    3
`define CW_MODE_LO    1
`define CW_BCD        0
`define RB_LATCH_CNT  5
`define RB_LATCH_STS  4
`define RB_SEL_BASE   1

`define SEL_READBACK  2'h3
`define RW_LATCH      2'h0
`define RW_LSB        2'h1
`define RW_MSB        2'h2
`define RW_BOTH       2'h3

`define RST_ACCESS    2'h3
`define RST_MODE      3'h0
`define RST_BCD       1'h0
`define RST_COUNT     16'h0000
`define RST_BYTE      8'h00

`endif

/* File: timer_pkg.sv */
package timer_pkg;

  typedef enum logic [1:0] {
    PH_LSB = 2'b01,
    PH_MSB = 2'b10
  } phase_type;

  typedef logic [1:0]  access_type;
  typedef logic [2:0]  mode_type;
  typedef logic [15:0] count_type;

endpackage

/* File: latch_if.sv */
`timescale 1ns/100ps
interface latch_if;
  import timer_pkg::*;
  logic       latch_cnt;
  logic       latch_sts;
  logic       rd_stb;
  logic       ctrl_wr;
  access_type access;
  count_type  live_count;
  logic [7:0] status_in;
  logic [7:0] rdata;

  modport top  (output latch_cnt, latch_sts, rd_stb, ctrl_wr, access,
                live_count, status_in,
                input  rdata);
  modport chan (input  latch_cnt, latch_sts, rd_stb, ctrl_wr, access,
                live_count, status_in,
                output rdata);
endinterface

/* File: readback_latch.sv */
`timescale 1ns/100ps
`include "timer_map.svh"
module readback_latch
  import timer_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Top side
  latch_if.chan    lif
);

  logic [7:0] sts_r, sts_nxt;
  logic       sts_vld_r, sts_vld_nxt;
  count_type  cnt_r, cnt_nxt;
  logic       cnt_vld_r, cnt_vld_nxt;
  phase_type  ph_r, ph_nxt;
  logic       last_byte;
  count_type  src;
  logic       hi_sel;

  always_comb begin
    sts_nxt     = sts_r;
    sts_vld_nxt = sts_vld_r;
    cnt_nxt     = cnt_r;
    cnt_vld_nxt = cnt_vld_r;
    ph_nxt      = ph_r;
    last_byte   = (lif.access != `RW_BOTH) || (ph_r == PH_MSB);
    if (lif.ctrl_wr) begin
      ph_nxt = PH_LSB;
    end
    if (lif.rd_stb) begin
      if (sts_vld_r) begin
        sts_vld_nxt = 1'b0;
      end else begin
        if (lif.access == `RW_BOTH) begin
          case (ph_r)
            PH_LSB:  ph_nxt = PH_MSB;
            PH_MSB:  ph_nxt = PH_LSB;
            default: ph_nxt = PH_LSB;
          endcase
        end
        if (cnt_vld_r && last_byte) begin
          cnt_vld_nxt = 1'b0;
        end
      end
    end
    if (lif.latch_sts && !sts_vld_r) begin
      sts_nxt     = lif.status_in;
      sts_vld_nxt = 1'b1;
    end
    if (lif.latch_cnt && !cnt_vld_r) begin
      cnt_nxt     = lif.live_count;
      cnt_vld_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sts_r     <= `RST_BYTE;
      sts_vld_r <= 1'b0;
      cnt_r     <= `RST_COUNT;
      cnt_vld_r <= 1'b0;
      ph_r      <= PH_LSB;
    end else begin
      sts_r     <= sts_nxt;
      sts_vld_r <= sts_vld_nxt;
      cnt_r     <= cnt_nxt;
      cnt_vld_r <= cnt_vld_nxt;
      ph_r      <= ph_nxt;
    end
  end

  always_comb begin
    src    = cnt_vld_r ? cnt_r : lif.live_count;
    hi_sel = (lif.access == `RW_MSB) ||
             ((lif.access == `RW_BOTH) && (ph_r == PH_MSB));
    if (sts_vld_r) begin
      lif.rdata = sts_r;
    end else if (hi_sel) begin
      lif.rdata = src[15:8];
    end else begin
      lif.rdata = src[7:0];
    end
  end

endmodule

/* File: interval_timer_readback_latch.sv */
`timescale 1ns/100ps
`include "timer_map.svh"
module interval_timer_readback_latch
  import timer_pkg::*;
(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  // I/O space access
  input  wire logic [7:0]       io_addr,
  input  wire logic             io_wr,
  input  wire logic             io_rd,
  input  wire logic [7:0]       io_wdata,
  output logic      [7:0]       io_rdata,
  // Counting elements
  input  wire logic [2:0][15:0] ce_count,
  input  wire logic [2:0]       ce_out,
  input  wire logic [2:0]       ce_loaded,
  input  wire logic             speaker_gate,
  // Programming towards counting elements
  output logic      [2:0][15:0] count_holding_register,
  output logic      [2:0]       cr_load,
  output logic      [2:0][2:0]  mode_sel,
  output logic      [2:0]       bcd_sel,
  // Derived outputs
  output logic      [2:0]       timer_out,
  output logic                  tick_irq,
  output logic                  refresh_req,
  output logic                  speaker
);

  logic       ctrl_hit;
  logic [1:0] cw_sel;
  logic [1:0] cw_rw;
  logic       is_readback;
  logic [2:0][7:0] ch_rdata;
  logic [2:0]      port_hit;

  assign ctrl_hit    = io_wr && (io_addr == `PORT_CTRL);
  assign cw_sel      = io_wdata[`CW_SEL_HI:`CW_SEL_LO];
  assign cw_rw       = io_wdata[`CW_RW_HI:`CW_RW_LO];
  assign is_readback = ctrl_hit && (cw_sel == `SEL_READBACK);

  assign port_hit[0] = (io_addr == `PORT_CNT0);
  assign port_hit[1] = (io_addr == `PORT_CNT1);
  assign port_hit[2] = (io_addr == `PORT_CNT2);

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : ch
      latch_if lif();

      access_type access_r, access_nxt;
      mode_type   mode_r, mode_nxt;
      logic       bcd_r, bcd_nxt;
      logic       null_r, null_nxt;
      count_type  cr_r, cr_nxt;
      logic       load_r, load_nxt;
      phase_type  wr_ph_r, wr_ph_nxt;
      mode_type   msel_r, msel_nxt;
      logic       prog_hit;
      logic       single_latch;
      logic       rb_sel;
      logic       port_wr;

      assign single_latch = ctrl_hit && (cw_sel == 2'(g)) &&
                            (cw_rw == `RW_LATCH);
      assign prog_hit     = ctrl_hit && (cw_sel == 2'(g)) &&
                            (cw_rw != `RW_LATCH);
      assign rb_sel       = is_readback && io_wdata[`RB_SEL_BASE + g];
      assign port_wr      = io_wr && port_hit[g];

      assign lif.latch_cnt  = single_latch ||
                              (rb_sel && !io_wdata[`RB_LATCH_CNT]);
      assign lif.latch_sts  = rb_sel && !io_wdata[`RB_LATCH_STS];
      assign lif.rd_stb     = io_rd && port_hit[g];
      assign lif.ctrl_wr    = prog_hit;
      assign lif.access     = access_r;
      assign lif.live_count = ce_count[g];
      assign lif.status_in  = {ce_out[g], null_r, access_r, mode_r, bcd_r};
      assign ch_rdata[g]    = lif.rdata;

      readback_latch u_latch (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .lif     (lif.chan)
      );

      always_comb begin
        access_nxt = access_r;
        mode_nxt   = mode_r;
        bcd_nxt    = bcd_r;
        null_nxt   = null_r;
        cr_nxt     = cr_r;
        load_nxt   = 1'b0;
        wr_ph_nxt  = wr_ph_r;
        if (prog_hit) begin
          access_nxt = cw_rw;
          mode_nxt   = io_wdata[`CW_MODE_HI:`CW_MODE_LO];
          bcd_nxt    = io_wdata[`CW_BCD];
          wr_ph_nxt  = PH_LSB;
        end else if (port_wr) begin
          case (access_r)
            `RW_LSB: begin
              cr_nxt   = {8'h00, io_wdata};
              load_nxt = 1'b1;
            end
            `RW_MSB: begin
              cr_nxt   = {io_wdata, 8'h00};
              load_nxt = 1'b1;
            end
            default: begin
              case (wr_ph_r)
                PH_LSB: begin
                  cr_nxt[7:0] = io_wdata;
                  wr_ph_nxt   = PH_MSB;
                end
                PH_MSB: begin
                  cr_nxt[15:8] = io_wdata;
                  wr_ph_nxt    = PH_LSB;
                  load_nxt     = 1'b1;
                end
                default: wr_ph_nxt = PH_LSB;
              endcase
            end
          endcase
        end
        if (prog_hit || load_nxt) begin
          null_nxt = 1'b1;
        end else if (ce_loaded[g]) begin
          null_nxt = 1'b0;
        end
        if (mode_nxt[1]) begin
          msel_nxt = {1'b0, mode_nxt[1:0]};
        end else begin
          msel_nxt = mode_nxt;
        end
      end

      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          access_r <= `RST_ACCESS;
          mode_r   <= `RST_MODE;
          bcd_r    <= `RST_BCD;
          null_r   <= 1'b0;
          cr_r     <= `RST_COUNT;
          load_r   <= 1'b0;
          wr_ph_r  <= PH_LSB;
          msel_r   <= `RST_MODE;
        end else begin
          access_r <= access_nxt;
          mode_r   <= mode_nxt;
          bcd_r    <= bcd_nxt;
          null_r   <= null_nxt;
          cr_r     <= cr_nxt;
          load_r   <= load_nxt;
          wr_ph_r  <= wr_ph_nxt;
          msel_r   <= msel_nxt;
        end
      end

      assign count_holding_register[g] = cr_r;
      assign cr_load[g]                = load_r;
      assign mode_sel[g]               = msel_r;
      assign bcd_sel[g]                = bcd_r;
    end
  endgenerate

  logic [7:0] rdata_r, rdata_nxt;
  logic [2:0] out_r, out_nxt;
  logic       tick_r, tick_nxt;
  logic       refresh_r, refresh_nxt;
  logic       speaker_r, speaker_nxt;

  always_comb begin
    rdata_nxt = rdata_r;
    if (io_rd) begin
      if (port_hit[0]) begin
        rdata_nxt = ch_rdata[0];
      end else if (port_hit[1]) begin
        rdata_nxt = ch_rdata[1];
      end else if (port_hit[2]) begin
        rdata_nxt = ch_rdata[2];
      end else begin
        rdata_nxt = `RST_BYTE;
      end
    end
  end

  always_comb begin
    out_nxt     = ce_out;
    tick_nxt    = ce_out[0];
    refresh_nxt = ce_out[1];
    speaker_nxt = ce_out[2] && speaker_gate;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= `RST_BYTE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      out_r     <= 3'h0;
      tick_r    <= 1'b0;
      refresh_r <= 1'b0;
      speaker_r <= 1'b0;
    end else begin
      out_r     <= out_nxt;
      tick_r    <= tick_nxt;
      refresh_r <= refresh_nxt;
      speaker_r <= speaker_nxt;
    end
  end

  assign io_rdata    = rdata_r;
  assign timer_out   = out_r;
  assign tick_irq    = tick_r;
  assign refresh_req = refresh_r;
  assign speaker     = speaker_r;

endmodule

/* File: timer_readback_props.sv */
`timescale 1ns/100ps
module timer_readback_props
  import timer_pkg::*;
(
  // Clock and reset
  input wire logic             sys_clk,
  input wire logic             rstn,
  // I/O space access
  input wire logic [7:0]       io_addr,
  input wire logic             io_wr,
  input wire logic             io_rd,
  input wire logic [7:0]       io_wdata,
  input wire logic [7:0]       io_rdata,
  // Counting elements
  input wire logic [2:0][15:0] ce_count,
  input wire logic [2:0]       ce_out,
  input wire logic [2:0]       ce_loaded,
  input wire logic             speaker_gate,
  // Programming
  input wire logic [2:0][15:0] count_holding_register,
  input wire logic [2:0]       cr_load,
  input wire logic [2:0][2:0]  mode_sel,
  input wire logic [2:0]       bcd_sel,
  // Derived outputs
  input wire logic [2:0]       timer_out,
  input wire logic             tick_irq,
  input wire logic             refresh_req,
  input wire logic             speaker
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic       cw0;
  logic       cw_ctl;
  logic [2:0] mode_exp;
  assign cw_ctl = io_wr && io_addr == 8'h43;
  assign cw0 = cw_ctl && io_wdata[7:6] == 2'h0 && io_wdata[5:4] != 2'h0;
  // Bit 3 is a don't-care for modes 2 and 3
  assign mode_exp = io_wdata[2] ? {1'b0, io_wdata[2:1]} : io_wdata[3:1];

  chk_out_follow: assert property (
    $past(rstn) |-> timer_out == $past(ce_out))
    else $error("timer_out does not follow ce_out");
  chk_irq_refresh: assert property (
    $past(rstn) |-> tick_irq == $past(ce_out[0])
                    && refresh_req == $past(ce_out[1]))
    else $error("tick or refresh wrong");
  chk_speaker_gate: assert property (
    $past(rstn) |-> speaker == ($past(ce_out[2]) && $past(speaker_gate)))
    else $error("speaker wrong");
  chk_rdata_hold: assert property (
    $past(rstn) && !$past(io_rd) |-> $stable(io_rdata))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (
    io_rd && !(io_addr inside {[8'h40:8'h42]}) |=> io_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_mode_decode: assert property (
    cw0 |=> mode_sel[0] == $past(mode_exp))
    else $error("mode decode wrong");
  chk_bcd_select: assert property (
    cw0 |=> bcd_sel[0] == $past(io_wdata[0]))
    else $error("count type wrong");
  chk_readback_keep: assert property (
    cw_ctl && io_wdata[7:6] == 2'h3 |=> $stable(mode_sel) && $stable(bcd_sel))
    else $error("read-back changed setup");
  chk_latch_keep: assert property (
    cw_ctl && io_wdata[5:4] == 2'h0 |=> $stable(mode_sel))
    else $error("count latch changed mode");
  chk_load_cause: assert property (
    cr_load[0] |-> $past(io_wr) && $past(io_addr) == 8'h40)
    else $error("load pulse without port write");

  cover property (cw0);
  cover property (io_rd && io_addr == 8'h40);
  cover property (cr_load[0]);
endmodule

bind interval_timer_readback_latch timer_readback_props u_props (
  .sys_clk, .rstn, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
  .ce_count, .ce_out, .ce_loaded, .speaker_gate, .count_holding_register,
  .cr_load, .mode_sel, .bcd_sel, .timer_out, .tick_irq, .refresh_req,
  .speaker);

/* File: interval_timer_readback_latch_tb.sv */
`timescale 1ns/100ps
module interval_timer_readback_latch_tb;
  import timer_pkg::*;
  logic             sys_clk;
  logic             rstn;
  logic [7:0]       io_addr;
  logic             io_wr;
  logic             io_rd;
  logic [7:0]       io_wdata;
  logic [7:0]       io_rdata;
  logic [2:0][15:0] ce_count;
  logic [2:0]       ce_out;
  logic [2:0]       ce_loaded;
  logic             speaker_gate;
  logic [2:0][15:0] count_holding_register;
  logic [2:0]       cr_load;
  logic [2:0][2:0]  mode_sel;
  logic [2:0]       bcd_sel;
  logic [2:0]       timer_out;
  logic             tick_irq;
  logic             refresh_req;
  logic             speaker;
  int               num_errors;
  int               n_tests;

  interval_timer_readback_latch dut (
    .sys_clk, .rstn, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
    .ce_count, .ce_out, .ce_loaded, .speaker_gate, .count_holding_register,
    .cr_load, .mode_sel, .bcd_sel, .timer_out, .tick_irq, .refresh_req,
    .speaker);

  task automatic check(input logic [15:0] seen, exp, input string m);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t %s saw %h want %h", $time, m, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(negedge sys_clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge sys_clk);
    io_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, e, input string m);
    @(negedge sys_clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge sys_clk);
    io_rd = 1'b0;
    check(16'(io_rdata), 16'(e), m);
  endtask

  task automatic t_program;
    wr(8'h43, 8'h34);
    check(16'(mode_sel[0]), 16'h2, "mode");
    wr(8'h40, 8'h10);
    wr(8'h40, 8'h27);
    repeat (2) @(negedge sys_clk);
    check(count_holding_register[0], 16'h2710, "cr");
    for (int c = 0; c < 8; c++) begin
      wr(8'h43, {4'h7, c[2:0], c[0]});
      check(16'(mode_sel[1]), c[1] ? 16'(c[1:0]) : 16'(c[2:0]), "mmap");
      check(16'(bcd_sel[1]), 16'(c[0]), "bcd");
    end
    $display("program done");
  endtask

  task automatic t_readback;
    ce_count[0] = 16'h1234;
    ce_out[0] = 1'b1;
    ce_loaded[0] = 1'b1;
    @(negedge sys_clk);
    ce_loaded[0] = 1'b0;
    wr(8'h43, 8'hc2);
    ce_count[0] = 16'h5678;
    ce_out[0] = 1'b0;
    wr(8'h43, 8'hc2);
    rd(8'h40, 8'hb4, "sts");
    rd(8'h40, 8'h34, "lsb");
    rd(8'h40, 8'h12, "msb");
    rd(8'h40, 8'h78, "live");
    rd(8'h40, 8'h56, "live");
    wr(8'h40, 8'h01);
    wr(8'h40, 8'h02);
    wr(8'h43, 8'he2);
    wr(8'h43, 8'he2);
    rd(8'h40, 8'h74, "null");
    rd(8'h40, 8'h78, "old");
    rd(8'h40, 8'h56, "old");
    $display("readback done");
  endtask

  task automatic t_latch;
    wr(8'h43, 8'hb0);
    ce_count[2] = 16'habcd;
    wr(8'h43, 8'h80);
    ce_count[2] = 16'h1111;
    wr(8'h43, 8'h80);
    rd(8'h42, 8'hcd, "lat");
    wr(8'h43, 8'h34);
    rd(8'h42, 8'hab, "lat");
    ce_count[1] = 16'h0f0e;
    wr(8'h43, 8'hd4);
    ce_count[1] = 16'h0000;
    ce_count[2] = 16'h2222;
    rd(8'h42, 8'h22, "unsel");
    rd(8'h41, 8'h0e, "sel");
    rd(8'h41, 8'h0f, "sel");
    rd(8'h43, 8'h00, "ctl");
    rd(8'h44, 8'h00, "map");
    $display("latch done");
  endtask

  task automatic t_single;
    wr(8'h43, 8'h50);
    wr(8'h41, 8'h5a);
    repeat (2) @(negedge sys_clk);
    check(count_holding_register[1], 16'h005a, "lsbw");
    ce_count[1] = 16'h7788;
    rd(8'h41, 8'h88, "lsbr");
    rd(8'h41, 8'h88, "lsbr");
    wr(8'h43, 8'h60);
    wr(8'h41, 8'h5a);
    repeat (2) @(negedge sys_clk);
    check(count_holding_register[1], 16'h5a00, "msbw");
    wr(8'h43, 8'he4);
    rd(8'h41, 8'h60, "echo");
    rd(8'h41, 8'h77, "msbr");
    ce_out = 3'h6;
    speaker_gate = 1'b0;
    repeat (2) @(negedge sys_clk);
    check({13'h0, timer_out}, 16'h6, "out");
    check({14'h0, speaker, refresh_req}, 16'h1, "spk");
    speaker_gate = 1'b1;
    @(negedge sys_clk);
    check(16'(speaker), 16'h1, "spk");
    $display("single done");
  endtask

  task automatic results;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    #2000000;
    num_errors++;
    results;
  end

  initial begin
    num_errors = 0;
    n_tests = 0;
    rstn = 1'b0;
    io_addr = 8'h00;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
    ce_count = '0;
    ce_out = 3'h7;
    ce_loaded = 3'h0;
    speaker_gate = 1'b1;
    repeat (5) @(negedge sys_clk);
    check({12'h0, timer_out, speaker}, 16'h0, "rst");
    check({14'h0, tick_irq, refresh_req}, 16'h0, "rst");
    $display("reset done");
    rstn = 1'b1;
    ce_out = 3'h0;
    t_program;
    t_readback;
    t_latch;
    t_single;
    results;
  end
endmodule
